// File: logic/abca_alu.v
// abca_alu.v: accumulating bit-logic, compare, and-not, conditional add and
// begin-service-routine datapath; one registered result per operation issued outside a save, other than the service routine.
// assumes: decode supplies operands read from the register files; the core
// writes res_out back to the destination when res_valid_out is high.
//
// Function
// - accumulating and/andn/nor/or of two selected bits, anded into dest bit 0
// - accumulate-equal: bit 0 &= (first == second or sign-extended immediate)
// - signed greater-or-equal accumulate, immediate sign-extended
// - unsigned greater-or-equal accumulate, immediate zero-extended
// - signed less-than accumulate, immediate sign-extended
// - unsigned less-than accumulate, immediate zero-extended
// - accumulate-not-equal, other destination bits kept
// - single-bit and into bit 0, upper bits cleared
// - single-bit and with inverted second bit, upper bits cleared
// - bitwise first and not(second or zero-extended immediate)
// - service routine saves a2-a7, d0-d7 and pc at free context pointer
// - service routine loads priority from immediate low byte, sets enable
// - service routine allowed only in supervisor mode
// - long conditional add: nonzero condition adds, else copies first source
// - short conditional add uses d15 condition and four-bit immediate
`default_nettype none
`include "abca_defines.vh"

module abca_alu #(
    parameter WIDTH = 32
) (
    input  wire              ref_clk_in,
    input  wire              nrst_in,
    input  wire              issue_in,
    input  wire [4:0]        op_in,
    input  wire [WIDTH-1:0]  src_a_in,
    input  wire [WIDTH-1:0]  src_b_in,
    input  wire [WIDTH-1:0]  dst_old_in,
    input  wire [WIDTH-1:0]  cond_in,
    input  wire              use_imm_in,
    input  wire [8:0]        imm9_in,
    input  wire [3:0]        imm4_in,
    input  wire [4:0]        first_bit_position_in,
    input  wire [4:0]        second_bit_position_in,
    input  wire              supervisor_in,
    input  wire [WIDTH-1:0]  free_context_pointer_in,
    input  wire [WIDTH-1:0]  pc_in,
    input  wire [WIDTH-1:0]  ctx_data_in,
    output reg               res_valid_out,
    output reg  [WIDTH-1:0]  res_out,
    output reg               priv_fault_out,
    output reg  [7:0]        current_priority_number_out,
    output reg               interrupt_enable_flag_out,
    output reg               ctx_busy_out,
    output reg               ctx_we_out,
    output reg  [WIDTH-1:0]  ctx_addr_out,
    output reg  [WIDTH-1:0]  ctx_wdata_out,
    output reg  [4:0]        ctx_sel_out
);

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [WIDTH-1:0] sext9;
    input [8:0] v;
    begin
        sext9 = {{(WIDTH-9){v[8]}}, v};
    end
endfunction

function [WIDTH-1:0] zext9;
    input [8:0] v;
    begin
        zext9 = {{(WIDTH-9){1'b0}}, v};
    end
endfunction

function [WIDTH-1:0] sext4;
    input [3:0] v;
    begin
        sext4 = {{(WIDTH-4){v[3]}}, v};
    end
endfunction

function nonzero;
    input [WIDTH-1:0] v;
    begin
        nonzero = (v != {WIDTH{1'b0}});
    end
endfunction

// five-bit index reaches all of a 32-bit word; wider words lose the top
function pick_bit;
    input [WIDTH-1:0] v;
    input [4:0]       n;
    begin
        pick_bit = v[n];
    end
endfunction

// only bit 0 of an accumulate destination may change
function [WIDTH-1:0] accum;
    input [WIDTH-1:0] d;
    input             t;
    begin
        accum = {d[WIDTH-1:1], d[0] & t};
    end
endfunction

function last_slot;
    input [4:0] n;
    begin
        last_slot = (n == `ABCA_CTX_PC_IDX);
    end
endfunction

function [WIDTH-1:0] slot_addr;
    input [WIDTH-1:0] base;
    input [4:0]       n;
    begin
        slot_addr = base + {{(WIDTH-7){1'b0}}, n, 2'b00};
    end
endfunction

// ----------------------------------------------------------------
// operand selection
// ----------------------------------------------------------------
wire [WIDTH-1:0] opnd_s = use_imm_in ? sext9(imm9_in) : src_b_in;
wire [WIDTH-1:0] opnd_u = use_imm_in ? zext9(imm9_in) : src_b_in;
wire [WIDTH-1:0] opnd_4 = use_imm_in ? sext4(imm4_in) : src_b_in;
wire             bit_a  = pick_bit(src_a_in, first_bit_position_in);
wire             bit_b  = pick_bit(src_b_in, second_bit_position_in);
wire             cond_set = nonzero(cond_in);

// ----------------------------------------------------------------
// single-bit logic
// ----------------------------------------------------------------
wire             bl_and  = bit_a & bit_b;
wire             bl_andn = bit_a & ~bit_b;
wire             bl_nor  = ~(bit_a | bit_b);
wire             bl_or   = bit_a | bit_b;

// ----------------------------------------------------------------
// compare unit
// ----------------------------------------------------------------
// one comparator set shared by all six compare-accumulate forms, the case only picks
wire             cmp_eq  = (src_a_in == opnd_s);
wire             cmp_ges = ($signed(src_a_in) >= $signed(opnd_s));
wire             cmp_geu = (src_a_in >= opnd_u);
wire             cmp_lts = ($signed(src_a_in) < $signed(opnd_s));
wire             cmp_ltu = (src_a_in < opnd_u);

reg              done_nxt;
reg [WIDTH-1:0]  res_nxt;
reg              bsr_go;
reg              fault_nxt;

always @* begin
    done_nxt  = issue_in;
    res_nxt   = dst_old_in;
    bsr_go    = 1'b0;
    fault_nxt = 1'b0;
    case (op_in)
        `ABCA_OP_AND_AND_T:  res_nxt = accum(dst_old_in, bl_and);
        `ABCA_OP_AND_ANDN_T: res_nxt = accum(dst_old_in, bl_andn);
        `ABCA_OP_AND_NOR_T:  res_nxt = accum(dst_old_in, bl_nor);
        `ABCA_OP_AND_OR_T:   res_nxt = accum(dst_old_in, bl_or);
        `ABCA_OP_ACC_EQ:     res_nxt = accum(dst_old_in, cmp_eq);
        `ABCA_OP_ACC_GE:     res_nxt = accum(dst_old_in, cmp_ges);
        `ABCA_OP_ACC_GEU:    res_nxt = accum(dst_old_in, cmp_geu);
        `ABCA_OP_ACC_LT:     res_nxt = accum(dst_old_in, cmp_lts);
        `ABCA_OP_ACC_LTU:    res_nxt = accum(dst_old_in, cmp_ltu);
        `ABCA_OP_ACC_NE:     res_nxt = accum(dst_old_in, ~cmp_eq);
        `ABCA_OP_BIT_AND:    res_nxt = {{(WIDTH-1){1'b0}}, bl_and};
        `ABCA_OP_BIT_ANDN:   res_nxt = {{(WIDTH-1){1'b0}}, bl_andn};
        `ABCA_OP_ANDN:       res_nxt = src_a_in & ~opnd_u;
        `ABCA_OP_CADD:
            res_nxt = cond_set ? src_a_in + opnd_s : src_a_in;
        `ABCA_OP_CADD16:
            res_nxt = cond_set ? src_a_in + opnd_4 : src_a_in;
        `ABCA_OP_BSR: begin
            done_nxt  = 1'b0;
            bsr_go    = issue_in & supervisor_in;
            fault_nxt = issue_in & ~supervisor_in;
        end
        default: begin
            done_nxt = 1'b0;
        end
    endcase
end

// ----------------------------------------------------------------
// result register
// ----------------------------------------------------------------
// a busy sequencer swallows issues, so neither pulse may leave then
wire             valid_nxt  = done_nxt & ~ctx_busy_out;
wire             pfault_nxt = fault_nxt & ~ctx_busy_out;

always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        res_valid_out  <= 1'b0;
        res_out        <= `ABCA_RST_WORD;
        priv_fault_out <= 1'b0;
    end else begin
        res_valid_out  <= valid_nxt;
        res_out        <= res_nxt;
        priv_fault_out <= pfault_nxt;
    end
end

// ----------------------------------------------------------------
// lower context save sequencer
// ----------------------------------------------------------------
// one word per cycle; ctx_sel_out 0-7 picks d0-d7, 8-13 a2-a7, 14 the pc.
// issues during a save are ignored, decode must hold off on ctx_busy_out.
localparam [1:0] SAVE_IDLE = 2'b00;
localparam [1:0] SAVE_RUN  = 2'b01;

reg [1:0]       save_state_r;
reg [1:0]       save_state_nxt;
reg [4:0]       ctx_cnt_r;
reg [4:0]       ctx_cnt_nxt;
reg [WIDTH-1:0] ctx_base_r;
reg [WIDTH-1:0] ctx_base_nxt;
reg [WIDTH-1:0] ctx_pc_r;
reg [WIDTH-1:0] ctx_pc_nxt;
reg             busy_nxt;
reg             we_nxt;
reg [WIDTH-1:0] addr_nxt;
reg [WIDTH-1:0] wdata_nxt;
reg [4:0]       sel_nxt;
reg [7:0]       prio_nxt;
reg             ie_nxt;

always @* begin
    save_state_nxt = save_state_r;
    ctx_cnt_nxt    = ctx_cnt_r;
    ctx_base_nxt   = ctx_base_r;
    ctx_pc_nxt     = ctx_pc_r;
    busy_nxt       = ctx_busy_out;
    we_nxt         = 1'b0;
    addr_nxt       = ctx_addr_out;
    wdata_nxt      = ctx_wdata_out;
    sel_nxt        = ctx_sel_out;
    prio_nxt       = current_priority_number_out;
    ie_nxt         = interrupt_enable_flag_out;
    case (save_state_r)
        SAVE_IDLE: begin
            if (bsr_go) begin
                save_state_nxt = SAVE_RUN;
                busy_nxt       = 1'b1;
                ctx_cnt_nxt    = 5'h00;
                sel_nxt        = 5'h00;
                ctx_base_nxt   = free_context_pointer_in;
                ctx_pc_nxt     = pc_in;
                prio_nxt       = imm9_in[7:0];
                ie_nxt         = 1'b1;
            end
        end
        SAVE_RUN: begin
            // ctx_data_in answers ctx_sel_out combinationally
            we_nxt    = 1'b1;
            addr_nxt  = slot_addr(ctx_base_r, ctx_cnt_r);
            wdata_nxt = last_slot(ctx_cnt_r) ? ctx_pc_r : ctx_data_in;
            if (last_slot(ctx_cnt_r)) begin
                save_state_nxt = SAVE_IDLE;
                busy_nxt       = 1'b0;
            end else begin
                ctx_cnt_nxt = ctx_cnt_r + 5'h01;
                sel_nxt     = ctx_cnt_r + 5'h01;
            end
        end
        default: begin
            save_state_nxt = SAVE_IDLE;
            busy_nxt       = 1'b0;
        end
    endcase
end

// ----------------------------------------------------------------
// save registers
// ----------------------------------------------------------------
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        save_state_r                <= SAVE_IDLE;
        ctx_busy_out                <= 1'b0;
        ctx_we_out                  <= 1'b0;
        ctx_addr_out                <= `ABCA_RST_WORD;
        ctx_wdata_out               <= `ABCA_RST_WORD;
        ctx_sel_out                 <= `ABCA_RST_SLOT;
        ctx_cnt_r                   <= `ABCA_RST_SLOT;
        ctx_base_r                  <= `ABCA_RST_WORD;
        ctx_pc_r                    <= `ABCA_RST_WORD;
        current_priority_number_out <= `ABCA_RST_PRIO;
        interrupt_enable_flag_out   <= 1'b0;
    end else begin
        save_state_r                <= save_state_nxt;
        ctx_busy_out                <= busy_nxt;
        ctx_we_out                  <= we_nxt;
        ctx_addr_out                <= addr_nxt;
        ctx_wdata_out               <= wdata_nxt;
        ctx_sel_out                 <= sel_nxt;
        ctx_cnt_r                   <= ctx_cnt_nxt;
        ctx_base_r                  <= ctx_base_nxt;
        ctx_pc_r                    <= ctx_pc_nxt;
        current_priority_number_out <= prio_nxt;
        interrupt_enable_flag_out   <= ie_nxt;
    end
end

endmodule

`default_nettype wire

// File: logic/abca_defines.vh
// abca_defines.vh: operation codes and constants for the bit-compare alu
// assumes: included by logic/abca_alu.v only
`ifndef ABCA_DEFINES_VH
`define ABCA_DEFINES_VH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define ABCA_OP_NONE      5'h00
`define ABCA_OP_AND_AND_T 5'h01
`define ABCA_OP_AND_ANDN_T 5'h02
`define ABCA_OP_AND_NOR_T 5'h03
`define ABCA_OP_AND_OR_T  5'h04
`define ABCA_OP_ACC_EQ    5'h05
`define ABCA_OP_ACC_GE    5'h06
`define ABCA_OP_ACC_GEU   5'h07
`define ABCA_OP_ACC_LT    5'h08
`define ABCA_OP_ACC_LTU   5'h09
`define ABCA_OP_ACC_NE    5'h0a
`define ABCA_OP_BIT_AND   5'h0b
`define ABCA_OP_BIT_ANDN  5'h0c
`define ABCA_OP_ANDN      5'h0d
`define ABCA_OP_CADD      5'h0e
`define ABCA_OP_CADD16    5'h0f
`define ABCA_OP_BSR       5'h10

// ----------------------------------------------------------------
// context save layout and reset values
// ----------------------------------------------------------------
`define ABCA_CTX_WORDS    5'h0f
`define ABCA_CTX_PC_IDX   5'h0e
`define ABCA_CTX_A_IDX    5'h08
`define ABCA_RST_WORD     32'h0000_0000
`define ABCA_RST_PRIO     8'h00
`define ABCA_RST_SLOT     5'h00

`endif

// File: sim/abca_props.sv
// abca_props.sv: port assertions for the bit-compare alu
// assumes: bound to abca_alu at its default width of 32, one clock
`default_nettype none
module abca_props (
    input wire logic        ref_clk_in,
    input wire logic        nrst_in,
    input wire logic        issue_in,
    input wire logic [4:0]  op_in,
    input wire logic [31:0] src_a_in,
    input wire logic [31:0] src_b_in,
    input wire logic [31:0] dst_old_in,
    input wire logic [31:0] cond_in,
    input wire logic        use_imm_in,
    input wire logic [8:0]  imm9_in,
    input wire logic        supervisor_in,
    input wire logic [31:0] free_context_pointer_in,
    input wire logic        res_valid_out,
    input wire logic [31:0] res_out,
    input wire logic        priv_fault_out,
    input wire logic [7:0]  current_priority_number_out,
    input wire logic        interrupt_enable_flag_out,
    input wire logic        ctx_busy_out,
    input wire logic        ctx_we_out,
    input wire logic [31:0] ctx_addr_out
);
    // ----------------------------------------
    // expected values one cycle ahead
    // ----------------------------------------
    wire        go   = issue_in && !ctx_busy_out;
    wire [31:0] opb  = use_imm_in ? {{23{imm9_in[8]}}, imm9_in} : src_b_in;
    wire [31:0] eq_x = {dst_old_in[31:1], dst_old_in[0] & (src_a_in == opb)};
    wire [31:0] ad_x = (cond_in != 32'h0) ? src_a_in + opb : src_a_in;
    wire [31:0] an_x = src_a_in & ~src_b_in;
    wire [30:0] hi_x = dst_old_in[31:1];
    wire [7:0]  pr_x = imm9_in[7:0];
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);
    sequence bsr_go;
        go && op_in == 5'h10 && supervisor_in;
    endsequence
    sequence save_run;
        ctx_we_out [*8] ##1 ctx_we_out [*7] ##1 !ctx_we_out;
    endsequence
    alu_valid_a: assert property (go && op_in inside {[5'h01:5'h0f]} |=> res_valid_out)
        else $error("alu op gave no result");
    eq_result_a: assert property (go && op_in == 5'h05 |=> res_out == $past(eq_x))
        else $error("equal accumulate wrong");
    ne_keep_a: assert property (go && op_in == 5'h0a |=> res_out[31:1] == $past(hi_x))
        else $error("upper bits changed");
    andn_res_a: assert property (go && op_in == 5'h0d && !use_imm_in
        |=> res_out == $past(an_x))
        else $error("and-not wrong");
    bit_clear_a: assert property (go && op_in inside {5'h0b, 5'h0c}
        |=> res_out[31:1] == 31'h0)
        else $error("single-bit upper bits set");
    cadd_res_a: assert property (go && op_in == 5'h0e |=> res_out == $past(ad_x))
        else $error("conditional add wrong");
    bsr_fault_a: assert property (go && op_in == 5'h10 && !supervisor_in
        |=> priv_fault_out && !ctx_busy_out)
        else $error("user-mode service routine ran");
    bsr_state_a: assert property (bsr_go |=> ctx_busy_out && interrupt_enable_flag_out
        && current_priority_number_out == $past(pr_x))
        else $error("priority or enable wrong");
    save_burst_a: assert property (bsr_go |-> ##2 save_run)
        else $error("save burst length wrong");
    save_base_a: assert property (bsr_go |-> ##2
        ctx_addr_out == $past(free_context_pointer_in, 2))
        else $error("save base wrong");
endmodule
bind abca_alu abca_props i_props (.ref_clk_in, .nrst_in, .issue_in, .op_in, .src_a_in,
    .src_b_in, .dst_old_in, .cond_in, .use_imm_in, .imm9_in, .supervisor_in,
    .free_context_pointer_in, .res_valid_out, .res_out, .priv_fault_out,
    .current_priority_number_out, .interrupt_enable_flag_out, .ctx_busy_out,
    .ctx_we_out, .ctx_addr_out);
`default_nettype wire

// File: sim/abca_tb.sv
// abca_tb.sv: self-checking bench for the bit-compare alu
// assumes: abca_alu and abca_props compiled first; the bench plays the core
`default_nettype none
module accumulating_bit_compare_alu_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, nrst = 1'b0, iss = 1'b0, ui = 1'b0, sup = 1'b0;
    logic        rv, pf, ie, bsy, we;
    logic [4:0]  op = 5'h00, fb = 5'h00, sb = 5'h00, sel;
    logic [3:0]  i4 = 4'h0;
    logic [8:0]  i9 = 9'h000;
    logic [7:0]  pri;
    logic [31:0] a = 32'h0, b = 32'h0, d = 32'h0, c = 32'h0, fcp = 32'h0, pc = 32'h0;
    logic [31:0] res, adr, wd;
    int          bad_count = 0;
    int          n_compared = 0;
    abca_alu i_dut (.ref_clk_in(clk), .nrst_in(nrst), .issue_in(iss), .op_in(op),
        .src_a_in(a), .src_b_in(b), .dst_old_in(d), .cond_in(c), .use_imm_in(ui),
        .imm9_in(i9), .imm4_in(i4), .first_bit_position_in(fb),
        .second_bit_position_in(sb), .supervisor_in(sup), .free_context_pointer_in(fcp),
        .pc_in(pc), .ctx_data_in(32'hc0de_0000 | {27'h0, sel}), .res_valid_out(rv),
        .res_out(res), .priv_fault_out(pf), .current_priority_number_out(pri),
        .interrupt_enable_flag_out(ie), .ctx_busy_out(bsy), .ctx_we_out(we),
        .ctx_addr_out(adr), .ctx_wdata_out(wd), .ctx_sel_out(sel));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] ref_res(input logic [4:0] o);
        logic [31:0] bo;
        logic        x, y, t;
        x  = a[fb];
        y  = b[sb];
        bo = ui ? {{23{i9[8] & o != 5'h07 & o != 5'h09 & o != 5'h0d}}, i9} : b;
        if (o == 5'h0f && ui) bo = {{28{i4[3]}}, i4};
        case (o)
            5'h01: t = x & y;
            5'h02: t = x & ~y;
            5'h03: t = ~(x | y);
            5'h04: t = x | y;
            5'h05: t = a == bo;
            5'h06: t = $signed(a) >= $signed(bo);
            5'h07: t = a >= bo;
            5'h08: t = $signed(a) < $signed(bo);
            5'h09: t = a < bo;
            5'h0a: t = a != bo;
            5'h0b: return {31'h0, x & y};
            5'h0c: return {31'h0, x & ~y};
            5'h0d: return a & ~bo;
            default: return (c != 32'h0) ? a + bo : a;
        endcase
        return {d[31:1], d[0] & t};
    endfunction
    task automatic run_op(input logic [4:0] o);
        @(posedge clk);
        #1;
        op  = o;
        iss = 1'b1;
        @(posedge clk);
        #1;
        iss = 1'b0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_ops(input logic imm);
        ui = imm;
        i9 = 9'h1f0;
        i4 = 4'h8;
        for (int p = 0; p < 2; p++) begin
            a  = p ? 32'h0000_0010 : 32'hffff_fff0;
            b  = 32'h0000_0010;
            d  = p ? 32'hffff_ffff : 32'h1234_5679;
            c  = p ? 32'h0 : 32'h8000_0000;
            fb = p ? 5'h00 : 5'h04;
            sb = p ? 5'h1f : 5'h04;
            for (int k = 1; k < 16; k++) begin
                run_op(k[4:0]);
                chk(res, ref_res(k[4:0]));
                chk({31'h0, rv}, 32'h1);
            end
        end
        $display("operand test done, immediate %0d", imm);
    endtask
    task automatic t_bsr();
        sup = 1'b1;
        fcp = 32'h0000_2000;
        pc  = 32'h0000_4444;
        i9  = 9'h1a5;
        run_op(5'h10);
        chk({23'h0, ie, pri}, 32'h0000_01a5);
        for (int k = 0; k < 15; k++) begin
            iss = (k == 3);
            op  = 5'h0d;
            @(posedge clk);
            #1;
            chk({30'h0, rv, we}, 32'h1);
            chk(adr, fcp + 32'(4 * k));
            chk(wd, (k == 14) ? pc : 32'hc0de_0000 + 32'(k));
            chk({27'h0, sel}, (k == 14) ? 32'h0000_000e : 32'(k + 1));
        end
        iss = 1'b0;
        @(posedge clk);
        #1;
        chk({30'h0, we, bsy}, 32'h0);
        sup = 1'b0;
        i9  = 9'h033;
        run_op(5'h10);
        chk({22'h0, pf, bsy, pri}, 32'h0000_02a5);
        $display("service routine test done");
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #10 clk = ~clk;
    end
    // watchdog: the run needs well under 300 cycles
    initial begin
        #20000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_ops(1'b0);
        t_ops(1'b1);
        t_bsr();
        summarize();
    end
endmodule
`default_nettype wire
